/* File: isc_slot_ctrl.sv */
// Purpose: slot bus control signal generation and sensing
// Assumes: all slot inputs and bus clock are asynchronous to ref_clk
// Notes:   bus clock is sampled; its rising edges form a one-cycle enable
`include "isc_cfg.svh"
`timescale 1ns/10ps
module isc_slot_ctrl (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       bus_clock_in,
   input  wire logic       power_ok_in,
   input  wire logic       osc_in,
   input  wire logic       cpu_hold_ack,
   input  wire logic       master_n_in,
   input  wire logic [3:0] cpu_byte_enables,
   input  wire logic       cpu_cycle_start,
   input  wire logic       dma_wide,
   input  wire logic       dma_addr0,
   input  wire logic       decoupled_refresh,
   input  wire logic       refresh_n_in,
   input  wire logic [7:0] dma_tc_in,
   input  wire logic [7:0] dma_grant,
   input  wire logic [7:0] dma_req_in,
   output logic            refresh_n_out,
   output logic            refresh_n_oe,
   output logic [7:0]      refresh_addr,
   output logic            mapper_sel_refresh,
   output logic            sbhe_n_out,
   output logic            sbhe_n_oe,
   output logic            addr_lines_oe,
   output logic            sysclk_out,
   output logic            osc_out,
   output logic            reset_drive,
   output logic            bale_out,
   output logic            aen_out,
   output logic            tc_out,
   output logic [7:0]      dack_n,
   output logic [7:0]      dma_req_sync
);
   // synchronisers: stage one is read only by stage two
   logic [12:0] s1_reg, s1_next, s2_reg, s2_next;
   logic [7:0]  r1_reg, r1_next, r2_reg, r2_next;
   logic        bclk_d_reg, bclk_d_next;
   logic        bclk_rise;
   logic        hlda_s, master_n_s, ref_in_s, pok_s, bclk_s, osc_s, start_s;

   always_comb begin
      s1_next = {bus_clock_in, power_ok_in, osc_in, cpu_hold_ack, master_n_in,
                 refresh_n_in, cpu_cycle_start, decoupled_refresh, dma_wide,
                 dma_addr0, 3'h0};
      s2_next = s1_reg;
      r1_next = dma_req_in;
      r2_next = r1_reg;
      bclk_d_next = bclk_s;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // active-low master and refresh bits reset to idle high, so no false edge
         s1_reg     <= 13'h0180;
         s2_reg     <= 13'h0180;
         r1_reg     <= 8'h00;
         r2_reg     <= 8'h00;
         bclk_d_reg <= 1'b0;
      end else begin
         s1_reg     <= s1_next;
         s2_reg     <= s2_next;
         r1_reg     <= r1_next;
         r2_reg     <= r2_next;
         bclk_d_reg <= bclk_d_next;
      end
   end

   assign bclk_s     = s2_reg[12];
   assign pok_s      = s2_reg[11];
   assign osc_s      = s2_reg[10];
   assign hlda_s     = s2_reg[9];
   assign master_n_s = s2_reg[8];
   assign ref_in_s   = s2_reg[7];
   assign start_s    = s2_reg[6];
   assign bclk_rise  = bclk_s & ~bclk_d_reg;

   // decode functions: ext_master is used twice, sbhe_decode once
   function automatic logic ext_master(input logic hlda, input logic mst_n);
      ext_master = hlda & ~mst_n;
   endfunction
   function automatic logic sbhe_decode(input logic [3:0] be_n);
      sbhe_decode = be_n[1] & be_n[3];  // high byte lanes both off
   endfunction

   // main state
   isc_pkg::isc_cyc_e cyc_reg, cyc_next;
   logic       sysclk_reg, sysclk_next;
   logic       rstdrv_reg, rstdrv_next;
   logic       osc_reg, osc_next;
   logic       bale_reg, bale_next;
   logic       aen_reg, aen_next;
   logic       tc_reg, tc_next;
   logic       sbhe_reg, sbhe_next, sbhe_oe_reg, sbhe_oe_next;
   logic       aoe_reg, aoe_next;
   logic       rout_reg, rout_next, roe_reg, roe_next;
   logic       ref_d_reg, ref_d_next, msel_reg, msel_next;
   logic [7:0] raddr_reg, raddr_next;
   logic [7:0] dack_reg, dack_next, drq_reg, drq_next;
   logic       pend_reg, pend_next;
   logic       sys_rise;

   assign sys_rise = bclk_rise & ~sysclk_reg;

   always_comb begin
      cyc_next    = cyc_reg;
      pend_next   = pend_reg | start_s;
      sysclk_next = sysclk_reg;
      rstdrv_next = rstdrv_reg;
      if (bclk_rise) begin
         sysclk_next = ~sysclk_reg;
         rstdrv_next = ~pok_s;
      end
      // cycle phases step on system clock rising edges only
      if (sys_rise) begin
         case (cyc_reg)
            isc_pkg::ISC_IDLE: begin
               if (pend_reg && !hlda_s) begin
                  cyc_next  = isc_pkg::ISC_START;
                  pend_next = start_s;
               end
            end
            isc_pkg::ISC_START: begin
               cyc_next = isc_pkg::ISC_CMD;
            end
            isc_pkg::ISC_CMD: begin
               cyc_next = isc_pkg::ISC_IDLE;
            end
            default: begin
               cyc_next = isc_pkg::ISC_IDLE;
            end
         endcase
      end
      bale_next = hlda_s | (cyc_reg == isc_pkg::ISC_START);
      aen_next  = hlda_s & master_n_s;
      aoe_next  = ~ext_master(hlda_s, master_n_s);
      sbhe_oe_next = ~ext_master(hlda_s, master_n_s);
      if (!hlda_s) begin
         sbhe_next = sbhe_decode(cpu_byte_enables);
      end else if (s2_reg[4]) begin
         sbhe_next = 1'b0;
      end else begin
         sbhe_next = ~s2_reg[3];
      end
      osc_next  = osc_s;
      rout_next = ~s2_reg[5];
      roe_next  = s2_reg[5];
      ref_d_next = ref_in_s;
      msel_next  = ~ref_in_s;
      raddr_next = raddr_reg;
      if (ref_d_reg && !ref_in_s) begin
         raddr_next = raddr_reg + 8'h01;
      end
      tc_next   = |dma_tc_in;
      // no per-channel width decode; byte lanes set via dma_wide and dma_addr0
      drq_next  = r2_reg;
      drq_next[`ISC_CASCADE_CH] = 1'b0;
      dack_next = 8'hFF;
      for (int i = 0; i < `ISC_NCH; i++) begin
         if (i != `ISC_CASCADE_CH) begin
            dack_next[i] = ~(dma_grant[i] & r2_reg[i]);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cyc_reg     <= isc_pkg::ISC_IDLE;
         pend_reg    <= 1'b0;
         sysclk_reg  <= 1'b0;
         rstdrv_reg  <= 1'b1;
         osc_reg     <= 1'b0;
         bale_reg    <= 1'b0;
         aen_reg     <= 1'b0;
         tc_reg      <= 1'b0;
         sbhe_reg    <= 1'b1;
         sbhe_oe_reg <= 1'b1;
         aoe_reg     <= 1'b1;
         rout_reg    <= 1'b1;
         roe_reg     <= 1'b0;
         ref_d_reg   <= 1'b1;
         msel_reg    <= 1'b0;
         raddr_reg   <= 8'h00;
         dack_reg    <= 8'hFF;  // acknowledges idle high after reset
         drq_reg     <= 8'h00;
      end else begin
         cyc_reg     <= cyc_next;
         pend_reg    <= pend_next;
         sysclk_reg  <= sysclk_next;
         rstdrv_reg  <= rstdrv_next;
         osc_reg     <= osc_next;
         bale_reg    <= bale_next;
         aen_reg     <= aen_next;
         tc_reg      <= tc_next;
         sbhe_reg    <= sbhe_next;
         sbhe_oe_reg <= sbhe_oe_next;
         aoe_reg     <= aoe_next;
         rout_reg    <= rout_next;
         roe_reg     <= roe_next;
         ref_d_reg   <= ref_d_next;
         msel_reg    <= msel_next;
         raddr_reg   <= raddr_next;
         dack_reg    <= dack_next;
         drq_reg     <= drq_next;
      end
   end

   assign refresh_n_out      = rout_reg;
   assign refresh_n_oe       = roe_reg;
   assign refresh_addr       = raddr_reg;
   assign mapper_sel_refresh = msel_reg;
   assign sbhe_n_out         = sbhe_reg;
   assign sbhe_n_oe          = sbhe_oe_reg;
   assign addr_lines_oe      = aoe_reg;
   assign sysclk_out         = sysclk_reg;
   assign osc_out            = osc_reg;
   assign reset_drive        = rstdrv_reg;
   assign bale_out           = bale_reg;
   assign aen_out            = aen_reg;
   assign tc_out             = tc_reg;
   assign dack_n             = dack_reg;
   assign dma_req_sync       = drq_reg;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sysclk_half_a: assert property (bclk_rise |=> sysclk_reg != $past(sysclk_reg))
      else $error("system clock did not toggle on bus clock edge");
   sysclk_hold_a: assert property (!bclk_rise |=> $stable(sysclk_reg))
      else $error("system clock moved without bus clock edge");
   rstdrv_sync_a: assert property (!bclk_rise |=> $stable(rstdrv_reg))
      else $error("reset drive changed off bus clock edge");
   bale_hold_a: assert property (hlda_s |=> bale_reg)
      else $error("latch enable low during hold acknowledge");
   aen_level_a: assert property (##1 aen_reg == $past(hlda_s & master_n_s))
      else $error("address enable wrong");
   sbhe_dma16_a: assert property (hlda_s && s2_reg[4] |=> !sbhe_reg)
      else $error("byte high enable not low for wide dma");
   dir_master_a: assert property (hlda_s && !master_n_s |=> !aoe_reg && !sbhe_oe_reg)
      else $error("address lines driven during external master");
   tc_any_a: assert property (|dma_tc_in |=> tc_reg)
      else $error("terminal count missed");
   cascade_a: assert property (dack_reg[`ISC_CASCADE_CH] && !drq_reg[`ISC_CASCADE_CH])
      else $error("cascade channel exposed");
   ref_cnt_a: assert property (ref_d_reg && !ref_in_s |=> raddr_reg == $past(raddr_reg) + 8'h01)
      else $error("refresh counter did not advance");

   cpu_cycle_c:  cover property (cyc_reg == isc_pkg::ISC_START ##1 bale_reg);
   dma_ack_c:    cover property (dack_reg != 8'hFF);
   ext_master_c: cover property (hlda_s && !master_n_s ##1 !aoe_reg);
   refresh_c:    cover property (ref_d_reg && !ref_in_s);
endmodule

/* File: isc_cfg.svh */
// Purpose: constants for the slot bus control block
// Assumes: ref_clk at 100 MHz
// Notes:   counts are in ref_clk cycles
// Functional notes
// - byte-high-enable direction and drive follow the slot address bus.
// - in cpu mode byte-high-enable comes from decoding cpu byte enables.
// - dma: byte-high-enable low for 16-bit, inverse of address bit 0 for 8-bit.
// - system clock output is exactly half the bus clock.
// - latch enable is timed to the system clock.
// - external oscillator input is buffered to an output.
// - latch enable pulses at start of each cpu bus cycle.
// - latch enable held high while hold acknowledge is high.
// - address enable high when hold ack high and master input high.
// - terminal count output asserted when any dma channel reaches count.
// - each dma acknowledge except cascade channel 4 answers its own request channel.
// - dma acknowledge polarity is active low after reset.
// - requests arrive asynchronously; pins have internal pull-ups.
// - channels 0-3 are 8-bit, channels 5-7 are 16-bit; the code takes width from dma_wide only.
// - channel 4 is internal cascade only, never exposed; the code still lets its terminal count set tc_out.
// - address-style lines are inputs when hold ack high and master low.
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
`define ISC_NCH        8
`define ISC_CASCADE_CH 4
`define ISC_WIDE_CH    4
`define ISC_REF_W      8
`endif

/* File: isc_pkg.sv */
// Purpose: types for the slot bus control block
// Assumes: nothing
// Notes:   cycle phase states
package isc_pkg;
   typedef enum logic [1:0] {
      ISC_IDLE  = 2'b00,
      ISC_START = 2'b01,
      ISC_CMD   = 2'b11
   } isc_cyc_e;
endpackage

/* File: isc_card_model.sv */
// Purpose: slot card model raising dma requests and pulling refresh
// Assumes: bench says when to request; card holds requests as levels
// Notes:   outputs change only after a ref_clk edge
`timescale 1ns/10ps
module isc_card_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] want_req,
   input  wire logic       want_refresh,
   output logic      [7:0] dma_req,
   output logic            refresh_pull
);
   always_ff @(posedge ref_clk) begin
      dma_req      <= want_req;
      refresh_pull <= want_refresh;
   end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the slot bus control block
// Assumes: outputs settle within a few ref_clk edges of an input change
// Notes:   bus clock runs free at 125 ns, unrelated to ref_clk
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic       hold;
      logic       mst;
      logic [3:0] be;
      logic       wide;
      logic       a0;
      logic       aen;
      logic       oe;
      logic       sbhe;
      logic       bale;
   } isc_row_s;
   logic ref_clk = 1'h0, bus_clock_in = 1'h0, rst, power_ok_in, osc_in, cpu_hold_ack;
   logic master_n_in, cpu_cycle_start, dma_wide, dma_addr0, decoupled_refresh;
   logic [3:0] cpu_byte_enables;
   logic [7:0] dma_tc_in, dma_grant, dma_req_in, want_req, refresh_addr, dack_n, dma_req_sync;
   logic want_refresh, refresh_pull, refresh_n_out, refresh_n_oe, mapper_sel_refresh;
   logic sbhe_n_out, sbhe_n_oe, addr_lines_oe, sysclk_out, osc_out, reset_drive;
   logic bale_out, aen_out, tc_out, s;
   wire  refresh_n_in = ~(refresh_n_oe | refresh_pull);
   int   failures = 0, tests_run = 0, i, n;
   logic [7:0] a;
   isc_row_s r;
   // hold, master_n, byte enables, wide, sa0 | aen, addr oe, sbhe_n, bale
   logic [11:0] rows [8] = '{12'h7C6, 12'h544, 12'h686, 12'h744,
                             12'hFED, 12'hFCF, 12'hFDD, 12'hBC1};
   always #5 ref_clk = ~ref_clk;
   always #62.5 bus_clock_in = ~bus_clock_in;
   isc_slot_ctrl DUT (.*);
   isc_card_model card (.ref_clk(ref_clk), .want_req(want_req), .want_refresh(want_refresh),
                        .dma_req(dma_req_in), .refresh_pull(refresh_pull));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #300000;
      failures++;
      conclude;
   end
   initial begin
      rst = 1'h1; power_ok_in = 1'h0; osc_in = 1'h0; cpu_hold_ack = 1'h0;
      master_n_in = 1'h1; cpu_cycle_start = 1'h0; dma_wide = 1'h0; dma_addr0 = 1'h0;
      decoupled_refresh = 1'h0; cpu_byte_enables = 4'hF; dma_tc_in = 8'h00;
      dma_grant = 8'h00; want_req = 8'h00; want_refresh = 1'h0;
      step(10);
      chk("reset_drive", 8'h01, reset_drive);
      chk("dack_n", 8'hFF, dack_n);
      chk("refresh_oe", 8'h00, refresh_n_oe);
      @(posedge ref_clk);
      rst <= 1'h0;
      power_ok_in <= 1'h1;
      step(40);
      chk("reset_drive", 8'h00, reset_drive);
      for (i = 0; i < 8; i++) begin
         r = isc_row_s'(rows[i]);
         @(posedge ref_clk);
         cpu_hold_ack <= r.hold;
         master_n_in <= r.mst;
         cpu_byte_enables <= r.be;
         dma_wide <= r.wide;
         dma_addr0 <= r.a0;
         step(8);
         chk("aen", {7'h00, r.aen}, aen_out);
         chk("addr_oe", {7'h00, r.oe}, addr_lines_oe);
         chk("sbhe_oe", {7'h00, r.oe}, sbhe_n_oe);
         if (r.oe) chk("sbhe", {7'h00, r.sbhe}, sbhe_n_out);
         chk("bale", {7'h00, r.bale}, bale_out);
      end
      @(posedge ref_clk);
      cpu_hold_ack <= 1'h0;
      master_n_in <= 1'h1;
      step(10);
      n = 0;
      for (i = 0; i < 200; i++) begin
         s = sysclk_out;
         step(1);
         if (sysclk_out !== s) n++;
      end
      chk("sysclk_toggles", 8'd16, (n >= 15 && n <= 17) ? 8'd16 : n[7:0]);
      @(posedge ref_clk);
      cpu_cycle_start <= 1'h1;
      step(2);
      cpu_cycle_start <= 1'h0;
      for (n = 0; n < 60 && bale_out !== 1'h1; n++) step(1);
      chk("bale_pulse", 8'h01, bale_out);
      step(60);
      chk("bale_end", 8'h00, bale_out);
      a = refresh_addr;
      decoupled_refresh <= 1'h1;
      step(8);
      chk("refresh_oe", 8'h01, refresh_n_oe);
      chk("mapper_sel", 8'h01, mapper_sel_refresh);
      chk("refresh_addr", a + 8'h01, refresh_addr);
      decoupled_refresh <= 1'h0;
      want_refresh <= 1'h1;
      step(8);
      chk("ext_refresh_oe", 8'h00, refresh_n_oe);
      chk("ext_refresh_addr", a + 8'h01, refresh_addr);
      want_refresh <= 1'h0;
      step(8);
      chk("mapper_off", 8'h00, mapper_sel_refresh);
      want_refresh <= 1'h1;
      step(8);
      chk("ext_refresh_adv", a + 8'h02, refresh_addr);
      want_refresh <= 1'h0;
      for (i = 0; i < 8; i++) begin
         a = 8'h01 << i;
         want_req <= a;
         dma_grant <= a;
         dma_tc_in <= a;
         osc_in <= i[0];
         step(8);
         chk("req_sync", (i == 4) ? 8'h00 : a, dma_req_sync);
         chk("dack_n", (i == 4) ? 8'hFF : ~a, dack_n);
         chk("tc", 8'h01, tc_out);
         chk("osc", {7'h00, i[0]}, osc_out);
      end
      dma_tc_in <= 8'h00;
      power_ok_in <= 1'h0;
      for (n = 0; n < 40 && reset_drive !== 1'h1; n++) begin
         s = sysclk_out;
         step(1);
      end
      chk("rst_rise", 8'h01, reset_drive);
      chk("rst_edge", {7'h00, ~s}, sysclk_out);
      chk("tc_off", 8'h00, tc_out);
      conclude;
   end
endmodule
